// ===== gclk_consts.svh
// Notes on behaviour
// - Status selector routes frame loss or clock loss, and alarm, freeze or signal loss
// - Legacy bit remaps system clock, output clock and select pins to status groups
// - Ganged interleave bit off uses internal mux; on disables it for wired-OR
// - Rising edge of counter latch bit pulses latch to all enabled framers
// - Interrupt inhibit forces low-active interrupt pin high; else follows interrupts
// - Interleave mode: off, two at 4.096, four at 8.192, eight at 16.384 MHz
// - Backplane frequency field selects 2.048, 4.096, 8.192 or 16.384 MHz
// - Receive sync select picks frame sync at 0, multiframe sync at 1
// - Transmit channel pins carry channel block at 0, channel clock at 1
// - Receive channel pins carry channel block at 0, channel clock at 1
// - System sync direction: inputs at 0, outputs on backplane clock at 1 when transmit sync select is set and legacy is off
// - Transmit sync pins carry per-channel sync at 0, system sync at 1 unless legacy is set
// - Reference select: recovered clocks 1 to 8, master-derived out, or external in
// - Reference frequency bit: 2.048 MHz at 0, 1.544 MHz at 1
// - Master frequency bit and period field declare the master clock rate
// - Receive system clocks come from own pins at 0, backplane clock at 1
// - Transmit system clocks come from own pins at 0, backplane clock at 1
`ifndef GCLK_CONSTS_SVH
`define GCLK_CONSTS_SVH
`define IDX_TRANSCEIVER_CTL 10'h0F0
`define IDX_FRAMER_CTL 10'h0F1
`define IDX_SYNC_PIN_CTL 10'h0F2
`define IDX_CLOCK_CTL_ONE 10'h0F3
`define IDX_CLOCK_CTL_THREE 10'h0F4
`define ADDR_TRANSCEIVER_CTL {`IDX_TRANSCEIVER_CTL, 2'b00}
`define ADDR_FRAMER_CTL {`IDX_FRAMER_CTL, 2'b00}
`define ADDR_SYNC_PIN_CTL {`IDX_SYNC_PIN_CTL, 2'b00}
`define ADDR_CLOCK_CTL_ONE {`IDX_CLOCK_CTL_ONE, 2'b00}
`define ADDR_CLOCK_CTL_THREE {`IDX_CLOCK_CTL_THREE, 2'b00}
`define RESET_VALUE 8'h00
`define GTC_INHIBIT 0
`define GTC_LATCH 1
`define GTC_GANGED 2
`define GTC_LEGACY 3
`define GTC_SEL_LO 5
`define GTC_SEL_HI 7
`define GFC_RX_CHAN 0
`define GFC_TX_CHAN 1
`define GFC_RX_SYNC 2
`define GFC_BP_LO 4
`define GFC_BP_HI 5
`define GFC_IBO_LO 6
`define GFC_IBO_HI 7
`define GSP_TRANSMIT_SYNC_SEL 0
`define GSP_SS_DIR 1
`define GC1_MPS_LO 0
`define GC1_MPS_HI 1
`define GC1_FREQ 2
`define GC1_BFREQ 3
`define GC1_REF_LO 4
`define GC1_REF_HI 7
`define GC3_TX_SYSCLK 5
`define GC3_RX_SYSCLK 6
`define REF_MCLK_OUT 4'h8
`define REF_EXT_IN 4'h9
`define STATUS_SEL_RESV 3'h6
`endif

// ===== gclk_pkg.sv
package gclk_pkg;
    typedef enum logic [1:0] {
        IBO_OFF = 2'h0, IBO_TWO = 2'h1, IBO_FOUR = 2'h2, IBO_EIGHT = 2'h3
    } ibo_mode_t;
    typedef enum logic [3:0] {
        REF_IDLE = 4'h1, REF_RECOVERED = 4'h2, REF_MCLK = 4'h4,
        REF_EXTERNAL = 4'h8
    } ref_src_t;
endpackage

// ===== global_clock_pin_config.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "gclk_consts.svh"
module global_clock_pin_config (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] receive_frame_loss,
    input wire logic [7:0] transmit_clock_loss,
    input wire logic [7:0] alarm_indication,
    input wire logic [7:0] receive_signalling_freeze,
    input wire logic [7:0] framer_signal_loss,
    input wire logic [7:0] receive_frame_sync,
    input wire logic [7:0] receive_multiframe_sync,
    input wire logic [7:0] tx_channel_block,
    input wire logic [7:0] tx_channel_clock,
    input wire logic [7:0] rx_channel_block,
    input wire logic [7:0] rx_channel_clock,
    input wire logic [7:0] transmit_sync,
    input wire logic [7:0] transmit_system_sync,
    input wire logic [7:0] receive_system_clock,
    input wire logic [7:0] transmit_system_clock,
    input wire logic [7:0] recovered_clock,
    input wire logic backplane_clock_out,
    input wire logic clock_output_src,
    input wire logic spi_select_in,
    input wire logic interrupt_req,
    output logic interrupt_pin_n,
    output logic [7:0] status_group_a,
    output logic [7:0] status_group_b,
    output logic [7:0] rx_sysclk_pin_out,
    output logic [7:0] tx_sysclk_pin_out,
    output logic [7:0] sysclk_pin_oe,
    output logic clock_output_pin,
    output logic spi_select_pin,
    output logic [7:0] rx_sync_pins,
    output logic [7:0] tx_chan_pins,
    output logic [7:0] rx_chan_pins,
    output logic [7:0] tx_sync_pins,
    output logic tx_sync_pins_oe,
    output logic [7:0] rx_sysclk_used,
    output logic [7:0] tx_sysclk_used,
    output logic counter_latch_pulse,
    output logic internal_mux_en,
    output logic [1:0] interleave_mode_field,
    output logic [1:0] backplane_freq_field,
    output logic backplane_ref_freq,
    output logic master_freq_bit,
    output logic [1:0] master_period_field,
    output logic [3:0] backplane_ref_src,
    output logic [7:0] backplane_ref_clock,
    output logic reference_clock_pin_out,
    output logic reference_clock_pin_oe
);
    // ======================================================
    // Register file
    logic [7:0] trx_ctl_r, framer_ctl_r, sync_ctl_r, clk_one_r, clk_three_r;
    logic access;
    logic [4:0] hit;
    logic [4:0] wr_hit;
    logic [7:0] rd_byte;

    function automatic logic [7:0] pick(input logic s, input logic [7:0] a,
                                        input logic [7:0] b);
        pick = s ? b : a;
    endfunction

    // One-hot register select, all zero for an unmapped address
    function automatic logic [4:0] decode(input logic [11:0] a);
        case (a)
            `ADDR_TRANSCEIVER_CTL: decode = 5'h01;
            `ADDR_FRAMER_CTL: decode = 5'h02;
            `ADDR_SYNC_PIN_CTL: decode = 5'h04;
            `ADDR_CLOCK_CTL_ONE: decode = 5'h08;
            `ADDR_CLOCK_CTL_THREE: decode = 5'h10;
            default: decode = 5'h00;
        endcase
    endfunction

    assign access = psel && penable;
    assign hit = decode(paddr);
    assign wr_hit = (access && pwrite) ? hit : 5'h00;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trx_ctl_r <= `RESET_VALUE;
        end else if (wr_hit[0]) begin
            trx_ctl_r <= pwdata[7:0] & 8'hEF;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            framer_ctl_r <= `RESET_VALUE;
        end else if (wr_hit[1]) begin
            framer_ctl_r <= pwdata[7:0] & 8'hF7;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_ctl_r <= `RESET_VALUE;
        end else if (wr_hit[2]) begin
            sync_ctl_r <= pwdata[7:0] & 8'h03;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clk_one_r <= `RESET_VALUE;
        end else if (wr_hit[3]) begin
            clk_one_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clk_three_r <= `RESET_VALUE;
        end else if (wr_hit[4]) begin
            clk_three_r <= pwdata[7:0] & 8'h7F;
        end
    end

    always_comb begin
        case (paddr)
            `ADDR_TRANSCEIVER_CTL: rd_byte = trx_ctl_r;
            `ADDR_FRAMER_CTL: rd_byte = framer_ctl_r;
            `ADDR_SYNC_PIN_CTL: rd_byte = sync_ctl_r;
            `ADDR_CLOCK_CTL_ONE: rd_byte = clk_one_r;
            `ADDR_CLOCK_CTL_THREE: rd_byte = clk_three_r;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= {24'h000000, rd_byte};
            pslverr <= psel && !penable && (hit == 5'h00);
        end
    end

    // ======================================================
    // Input synchronisers
    logic [7:0] rfl_m, rfl_s, tcl_m, tcl_s, al_m, al_s, rsf_m, rsf_s;
    logic [7:0] fsl_m, fsl_s;
    logic irq_m, irq_s;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rfl_m <= 8'h00;
            rfl_s <= 8'h00;
            tcl_m <= 8'h00;
            tcl_s <= 8'h00;
            al_m <= 8'h00;
            al_s <= 8'h00;
            rsf_m <= 8'h00;
            rsf_s <= 8'h00;
            fsl_m <= 8'h00;
            fsl_s <= 8'h00;
        end else begin
            rfl_m <= receive_frame_loss;
            rfl_s <= rfl_m;
            tcl_m <= transmit_clock_loss;
            tcl_s <= tcl_m;
            al_m <= alarm_indication;
            al_s <= al_m;
            rsf_m <= receive_signalling_freeze;
            rsf_s <= rsf_m;
            fsl_m <= framer_signal_loss;
            fsl_s <= fsl_m;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_m <= 1'b0;
            irq_s <= 1'b0;
        end else begin
            irq_m <= interrupt_req;
            irq_s <= irq_m;
        end
    end

    // ======================================================
    // Status routing
    logic [2:0] sel;
    logic [7:0] grp_a, grp_b;
    logic legacy;
    assign sel = trx_ctl_r[`GTC_SEL_HI:`GTC_SEL_LO];
    assign legacy = trx_ctl_r[`GTC_LEGACY];
    always_comb begin
        if (sel >= `STATUS_SEL_RESV) begin
            grp_a = 8'h00;
            grp_b = 8'h00;
        end else begin
            grp_a = pick(sel[0], rfl_s, tcl_s);
            case (sel[2:1])
                2'h0: grp_b = al_s;
                2'h1: grp_b = rsf_s;
                default: grp_b = fsl_s;
            endcase
        end
    end

    logic latch_d_r;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            latch_d_r <= 1'b0;
            counter_latch_pulse <= 1'b0;
            interrupt_pin_n <= 1'b1;
        end else begin
            latch_d_r <= trx_ctl_r[`GTC_LATCH];
            counter_latch_pulse <= trx_ctl_r[`GTC_LATCH] && !latch_d_r;
            interrupt_pin_n <= trx_ctl_r[`GTC_INHIBIT] || !irq_s;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status_group_a <= 8'h00;
            status_group_b <= 8'h00;
        end else begin
            status_group_a <= grp_a;
            status_group_b <= grp_b;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_sysclk_pin_out <= 8'h00;
            tx_sysclk_pin_out <= 8'h00;
            sysclk_pin_oe <= 8'h00;
            clock_output_pin <= 1'b0;
            spi_select_pin <= 1'b0;
        end else begin
            rx_sysclk_pin_out <= legacy ? {grp_a[7:1], 1'b0} : 8'h00;
            tx_sysclk_pin_out <= legacy ? {grp_b[7:1], 1'b0} : 8'h00;
            sysclk_pin_oe <= legacy ? 8'hFE : 8'h00;
            clock_output_pin <= legacy ? grp_a[0] : clock_output_src;
            spi_select_pin <= legacy ? grp_b[0] : spi_select_in;
        end
    end

    // ======================================================
    // Pin function selects
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_sync_pins <= 8'h00;
            tx_chan_pins <= 8'h00;
            rx_chan_pins <= 8'h00;
        end else begin
            rx_sync_pins <= pick(framer_ctl_r[`GFC_RX_SYNC],
                receive_frame_sync, receive_multiframe_sync);
            tx_chan_pins <= pick(framer_ctl_r[`GFC_TX_CHAN],
                tx_channel_block, tx_channel_clock);
            rx_chan_pins <= pick(framer_ctl_r[`GFC_RX_CHAN],
                rx_channel_block, rx_channel_clock);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_sync_pins <= 8'h00;
            tx_sync_pins_oe <= 1'b0;
        end else begin
            tx_sync_pins <= (sync_ctl_r[`GSP_TRANSMIT_SYNC_SEL] && !legacy) ?
                transmit_system_sync : transmit_sync;
            tx_sync_pins_oe <= sync_ctl_r[`GSP_SS_DIR] &&
                sync_ctl_r[`GSP_TRANSMIT_SYNC_SEL] && !legacy;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_sysclk_used <= 8'h00;
            tx_sysclk_used <= 8'h00;
        end else begin
            rx_sysclk_used <= pick(clk_three_r[`GC3_RX_SYSCLK],
                receive_system_clock, {8{backplane_clock_out}});
            tx_sysclk_used <= pick(clk_three_r[`GC3_TX_SYSCLK],
                transmit_system_clock, {8{backplane_clock_out}});
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            internal_mux_en <= 1'b1;
            interleave_mode_field <= 2'h0;
            backplane_freq_field <= 2'h0;
        end else begin
            internal_mux_en <= !trx_ctl_r[`GTC_GANGED];
            interleave_mode_field <=
                framer_ctl_r[`GFC_IBO_HI:`GFC_IBO_LO];
            backplane_freq_field <=
                framer_ctl_r[`GFC_BP_HI:`GFC_BP_LO];
        end
    end

    // ======================================================
    // Clock reference selection
    logic [3:0] ref_code;
    logic [3:0] src;
    assign ref_code = clk_one_r[`GC1_REF_HI:`GC1_REF_LO];
    always_comb begin
        if (!ref_code[3])
            src = gclk_pkg::REF_RECOVERED;
        else if (ref_code == `REF_MCLK_OUT)
            src = gclk_pkg::REF_MCLK;
        else if (ref_code == `REF_EXT_IN)
            src = gclk_pkg::REF_EXTERNAL;
        else
            src = gclk_pkg::REF_IDLE;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            backplane_ref_src <= gclk_pkg::REF_RECOVERED;
            backplane_ref_clock <= 8'h00;
            reference_clock_pin_out <= 1'b0;
            reference_clock_pin_oe <= 1'b0;
        end else begin
            backplane_ref_src <= src;
            backplane_ref_clock <= (src == gclk_pkg::REF_RECOVERED) ?
                (8'h01 << ref_code[2:0]) & recovered_clock : 8'h00;
            reference_clock_pin_out <= (src == gclk_pkg::REF_MCLK) &&
                clock_output_src;
            reference_clock_pin_oe <= (src == gclk_pkg::REF_MCLK);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            backplane_ref_freq <= 1'b0;
            master_freq_bit <= 1'b0;
            master_period_field <= 2'h0;
        end else begin
            backplane_ref_freq <= clk_one_r[`GC1_BFREQ];
            master_freq_bit <= clk_one_r[`GC1_FREQ];
            master_period_field <= clk_one_r[`GC1_MPS_HI:`GC1_MPS_LO];
        end
    end
endmodule

// ===== gclk_monitor.sv
`timescale 1ns/10ps
`include "gclk_consts.svh"
module gclk_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic interrupt_pin_n,
    input wire logic counter_latch_pulse,
    input wire logic internal_mux_en,
    input wire logic [1:0] interleave_mode_field,
    input wire logic [1:0] backplane_freq_field,
    input wire logic backplane_ref_freq,
    input wire logic master_freq_bit,
    input wire logic [1:0] master_period_field,
    input wire logic [3:0] backplane_ref_src,
    input wire logic reference_clock_pin_oe
);
    // ==========================================
    // Shadow copies of the written transceiver, framer and clock one registers
    logic [7:0] tc_r;
    logic [7:0] fc_r;
    logic [7:0] c1_r;
    logic wr_ok;
    assign wr_ok = psel && penable && pready && pwrite;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tc_r <= 8'h00;
            fc_r <= 8'h00;
            c1_r <= 8'h00;
        end else if (wr_ok) begin
            if (paddr == `ADDR_TRANSCEIVER_CTL) tc_r <= pwdata[7:0];
            if (paddr == `ADDR_FRAMER_CTL) fc_r <= pwdata[7:0];
            if (paddr == `ADDR_CLOCK_CTL_ONE) c1_r <= pwdata[7:0];
        end
    end
    // ==========================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    AST_LATCH: assert property (counter_latch_pulse |->
        $past(tc_r[`GTC_LATCH]) ##1 !counter_latch_pulse)
        else $error("latch pulse not a single cycle after set");
    AST_INH_HIGH: assert property (tc_r[0] && $past(tc_r[0])
        |-> interrupt_pin_n) else $error("inhibited pin not high");
    AST_INH_LOW: assert property (!interrupt_pin_n |->
        !$past(tc_r[`GTC_INHIBIT])) else $error("pin low while inhibited");
    AST_MUX: assert property ($stable(tc_r[2]) |->
        internal_mux_en == !tc_r[`GTC_GANGED]) else $error("mux enable");
    AST_IBO: assert property ($stable(fc_r) |->
        interleave_mode_field == fc_r[7:6]) else $error("interleave mode");
    AST_BPF: assert property ($stable(fc_r) |->
        backplane_freq_field == fc_r[5:4]) else $error("backplane freq");
    AST_MCLK: assert property ($stable(c1_r) |->
        {backplane_ref_freq, master_freq_bit, master_period_field}
        == c1_r[3:0]) else $error("clock declaration fields");
    AST_REFOE: assert property ($stable(c1_r) |->
        reference_clock_pin_oe == (c1_r[7:4] == `REF_MCLK_OUT))
        else $error("reference pin enable");
    AST_RESV: assert property ($stable(c1_r) && c1_r[7:4] > `REF_EXT_IN
        |-> backplane_ref_src == gclk_pkg::REF_IDLE)
        else $error("reserved reference code selects a source");
    cover property (counter_latch_pulse);
    cover property (reference_clock_pin_oe);
    cover property (tc_r[0] && interrupt_pin_n);
endmodule
bind global_clock_pin_config gclk_monitor mon (.*);

// ===== tb_top.sv
`timescale 1ns/10ps
`include "gclk_consts.svh"
module tb_top;
    logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, interrupt_pin_n;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic backplane_clock_out, clock_output_src = 1'b0;
    logic spi_select_in = 1'b0, interrupt_req = 1'b0;
    logic [7:0] receive_frame_loss, transmit_clock_loss, alarm_indication;
    logic [7:0] receive_signalling_freeze, framer_signal_loss;
    logic [7:0] receive_frame_sync, receive_multiframe_sync, tx_channel_block;
    logic [7:0] tx_channel_clock, rx_channel_block, rx_channel_clock;
    logic [7:0] transmit_sync, transmit_system_sync, receive_system_clock;
    logic [7:0] transmit_system_clock, recovered_clock, status_group_a;
    logic [7:0] status_group_b, rx_sysclk_pin_out, tx_sysclk_pin_out;
    logic [7:0] sysclk_pin_oe, rx_sync_pins, tx_chan_pins, rx_chan_pins;
    logic [7:0] tx_sync_pins, rx_sysclk_used, tx_sysclk_used;
    logic [7:0] backplane_ref_clock, lf = 8'h36, ea, eb, d;
    logic clock_output_pin, spi_select_pin, tx_sync_pins_oe;
    logic counter_latch_pulse, internal_mux_en, backplane_ref_freq;
    logic master_freq_bit, reference_clock_pin_out, reference_clock_pin_oe;
    logic [1:0] interleave_mode_field, backplane_freq_field;
    logic [1:0] master_period_field;
    logic [3:0] backplane_ref_src, er;
    logic [32:0] exq[$];
    int fail_count = 0, compares = 0, pulses = 0;
    global_clock_pin_config dut (.*);
    always #25 clock = ~clock;
    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // Stimulus helpers
    task automatic stir();
        receive_frame_loss <= rnd();
        transmit_clock_loss <= rnd();
        alarm_indication <= rnd();
        receive_signalling_freeze <= rnd();
        framer_signal_loss <= rnd();
        receive_frame_sync <= rnd();
        receive_multiframe_sync <= rnd();
        tx_channel_block <= rnd();
        tx_channel_clock <= rnd();
        rx_channel_block <= rnd();
        rx_channel_clock <= rnd();
        transmit_sync <= rnd();
        transmit_system_sync <= rnd();
        receive_system_clock <= rnd();
        transmit_system_clock <= rnd();
        recovered_clock <= rnd();
        backplane_clock_out <= rnd() > 8'h7F;
        clock_output_src <= rnd() > 8'h7F;
        spi_select_in <= rnd() > 8'h7F;
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] v);
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, v};
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (w) repeat (6) @(posedge clock);
    endtask
    always @(posedge clock) begin
        if (counter_latch_pulse === 1'b1) pulses++;
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, exq.pop_front());
    end
    initial begin
        #(50 * 30000);
        fail_count++;
        close_out();
    end
    // ==========================================
    // Tests
    initial begin
        logic [11:0] ad[5];
        logic [7:0] mk[5];
        ad = '{`ADDR_TRANSCEIVER_CTL, `ADDR_FRAMER_CTL, `ADDR_SYNC_PIN_CTL,
            `ADDR_CLOCK_CTL_ONE, `ADDR_CLOCK_CTL_THREE};
        mk = '{8'hEF, 8'hF7, 8'h03, 8'hFF, 8'h60};
        stir();
        repeat (8) @(posedge clock);
        chk({interrupt_pin_n, internal_mux_en}, 2'b11);
        chk(backplane_ref_src, gclk_pkg::REF_RECOVERED);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            exq.push_back({25'h0, `RESET_VALUE});
            xfer(ad[i], 1'b0, 8'h00);
            d = rnd() & mk[i];
            xfer(ad[i], 1'b1, d);
            exq.push_back({25'h0, d});
            xfer(ad[i], 1'b0, 8'h00);
        end
        exq.push_back({1'b1, 32'h0});
        xfer(12'h3D4, 1'b0, 8'h00);
        $display("register test done");
        xfer(`ADDR_SYNC_PIN_CTL, 1'b1, 8'h03);
        for (int c = 0; c < 8; c++) begin
            stir();
            xfer(`ADDR_TRANSCEIVER_CTL, 1'b1, {c[2:0], 2'b01, c[0], 2'b00});
            ea = c > 5 ? 8'h00 : c[0] ? transmit_clock_loss : receive_frame_loss;
            eb = c > 5 ? 8'h00 : c[2] ? framer_signal_loss :
                c[1] ? receive_signalling_freeze : alarm_indication;
            chk(status_group_a, ea);
            chk(status_group_b, eb);
            chk({rx_sysclk_pin_out[7:1], clock_output_pin}, ea);
            chk({tx_sysclk_pin_out[7:1], spi_select_pin}, eb);
            chk({sysclk_pin_oe, tx_sync_pins_oe, tx_sync_pins},
                {8'hFE, 1'b0, transmit_sync});
            chk(internal_mux_en, !c[0]);
        end
        xfer(`ADDR_TRANSCEIVER_CTL, 1'b1, 8'h00);
        $display("status pin test done");
        for (int v = 0; v < 4; v++) begin
            stir();
            xfer(`ADDR_FRAMER_CTL, 1'b1, {v[1:0], v[1:0], 1'b0, {3{v[0]}}});
            xfer(`ADDR_SYNC_PIN_CTL, 1'b1, {6'h0, v[1:0]});
            xfer(`ADDR_CLOCK_CTL_THREE, 1'b1, {1'b0, v[1:0], 5'h00});
            chk({interleave_mode_field, backplane_freq_field}, {2{v[1:0]}});
            chk(rx_sync_pins, v[0] ? receive_multiframe_sync : receive_frame_sync);
            chk(tx_chan_pins, v[0] ? tx_channel_clock : tx_channel_block);
            chk(rx_chan_pins, v[0] ? rx_channel_clock : rx_channel_block);
            ea = v[0] ? transmit_system_sync : transmit_sync;
            chk(tx_sync_pins, ea);
            chk({rx_sysclk_pin_out, tx_sysclk_pin_out}, 16'h0000);
            chk(sysclk_pin_oe, 8'h00);
            chk({clock_output_pin, spi_select_pin},
                {clock_output_src, spi_select_in});
            chk(tx_sync_pins_oe, v == 3);
            chk(rx_sysclk_used, v[1] ? {8{backplane_clock_out}} : receive_system_clock);
            chk(tx_sysclk_used, v[0] ? {8{backplane_clock_out}} : transmit_system_clock);
        end
        $display("pin function test done");
        for (int r = 0; r < 16; r++) begin
            stir();
            xfer(`ADDR_CLOCK_CTL_ONE, 1'b1, {r[3:0], r[3:0]});
            er = r < 8 ? gclk_pkg::REF_RECOVERED : r == 8 ? gclk_pkg::REF_MCLK :
                r == 9 ? gclk_pkg::REF_EXTERNAL : gclk_pkg::REF_IDLE;
            chk(backplane_ref_src, er);
            chk(reference_clock_pin_oe, r == 8);
            chk({backplane_ref_freq, master_freq_bit, master_period_field}, r[3:0]);
            ea = r < 8 ? recovered_clock & (8'h01 << r) : 8'h00;
            chk(backplane_ref_clock, ea);
            chk(reference_clock_pin_out, r == 8 && clock_output_src);
        end
        $display("reference test done");
        pulses = 0;
        xfer(`ADDR_TRANSCEIVER_CTL, 1'b1, 8'h02);
        xfer(`ADDR_TRANSCEIVER_CTL, 1'b1, 8'h02);
        chk(pulses, 1);
        xfer(`ADDR_TRANSCEIVER_CTL, 1'b1, 8'h00);
        xfer(`ADDR_TRANSCEIVER_CTL, 1'b1, 8'h02);
        chk(pulses, 2);
        interrupt_req <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            xfer(`ADDR_TRANSCEIVER_CTL, 1'b1, {7'h00, i[0]});
            chk(interrupt_pin_n, i[0]);
        end
        $display("latch and interrupt test done");
        close_out();
    end
endmodule
